// file: rtl/cssw_pkg.sv
// package for the system clock source switch: encodings, reset values, pause counts
// assumes all source ticks and software strobes are synchronous to ref_clk
//
// Overview of operation
// - two-bit select field picks system clock source
// - 11 internal, 10 primary, 01 timer1, 00 default
// - source changes only after a transition interval, except the boot handover from low-freq rc to primary
// - primary done flag after startup timer, primary active
// - secondary active flag while timer1 source clocks
// - at most one status flag set at once
// - sleep command consults idle-on-sleep enable bit
// - enable 1 gives idle, 0 gives sleep
// - secondary select ignored when timer1 oscillator off
// - every reset clears the select field
// - internal reset default starts fast rc at 1 mhz
// - power-up runs low-freq rc until configuration loaded
// - two select encodings reach the same source
// - glitch-free pause: two old, three new cycles
// - configuration picks crystal, external or internal primary
// - low-freq rc always feeds watchdog and monitor
// - timer1 oscillator keeps running in power-managed modes

package cssw_pkg;

  // ----------------------------------------
  // select field encodings
  // ----------------------------------------
  localparam logic [1:0] SEL_INTERNAL = 2'h3;
  localparam logic [1:0] SEL_PRIMARY = 2'h2;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // ----------------------------------------
  // fast rc postscaler select
  // ----------------------------------------
  localparam logic [2:0] FREQ_RESET = 3'h4; // 1 mhz after reset
  localparam logic [2:0] FREQ_LOW = 3'h0; // 31 khz setting

  // ----------------------------------------
  // switch pause, in source cycles
  // ----------------------------------------
  localparam int OLD_TICKS = 2;
  localparam int NEW_TICKS = 3;
  localparam int CNT_W = 3;

  // clock sources, also the index into tick and stable vectors
  typedef enum logic [1:0] {SRC_LFRC, SRC_FASTRC, SRC_PRIMARY, SRC_SECOND} cssw_src_e;

  // primary oscillator configuration modes
  typedef enum logic [2:0] {
    crystal_mode, crystal_pll_mode, external_clock_mode, ext_clock_pll_mode,
    internal_lf_mode, internal_hf_mode, internal_pll_mode
  } cssw_pmode_e;

  // switch sequencer states
  typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_OLD, ST_STABLE, ST_NEW} cssw_state_e;

endpackage

// file: rtl/cssw_cnt_if.sv
// interface between the switch sequencer and its source-cycle counter
// assumes one clock domain, ref_clk
`timescale 1ns/10ps
`default_nettype none

interface cssw_cnt_if;
  import cssw_pkg::*;
  logic [3:0] tick_vec; // one tick per source, by source index
  cssw_src_e src; // source whose ticks are counted
  logic start; // pulse: restart counting
  logic [cssw_pkg::CNT_W-1:0] target; // ticks to count
  logic done; // pulse: target reached

  modport seq (output tick_vec, output src, output start, output target, input done);
  modport counter (input tick_vec, input src, input start, input target, output done);
endinterface

`default_nettype wire

// file: rtl/cssw_tick_count.sv
// counts ticks of one chosen clock source for the switch pause
// assumes start is a one-cycle pulse and target is at least one
`timescale 1ns/10ps
`default_nettype none

module cssw_tick_count (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // sequencer side
  cssw_cnt_if.counter cnt
);
  import cssw_pkg::*;

  logic [CNT_W-1:0] count_r; // ticks seen so far
  logic busy_r; // counting in progress
  logic done_r; // registered done pulse
  logic tick_sel; // tick of the counted source
  logic last_tick; // this tick reaches the target

  // ----------------------------------------
  // selection
  // ----------------------------------------
  assign tick_sel = cnt.tick_vec[cnt.src];
  assign last_tick = busy_r && !cnt.start && tick_sel && (count_r == cnt.target - 3'h1);
  assign cnt.done = done_r;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // a start always wins, so a stale count never leaks into the next pause
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= last_tick;
      if (cnt.start) begin
        count_r <= 3'h0;
        busy_r <= 1'b1;
      end else if (last_tick) begin
        busy_r <= 1'b0;
      end else if (busy_r && tick_sel) begin
        count_r <= count_r + 3'h1;
      end
    end
  end

  // done comes exactly one cycle after the final counted tick
  done_timing_a: assert property (@(posedge ref_clk) disable iff (!rstn) last_tick |=> cnt.done)
    else $error("counter done pulse missing");

endmodule

`default_nettype wire

// file: rtl/cssw_clock_switch.sv
// system clock source switch: select decode, glitch-free pause, status flags, sleep
// assumes source ticks and stable levels arrive as ref_clk-synchronous enables
`timescale 1ns/10ps
`default_nettype none

module cssw_clock_switch #(
  parameter int OLD_CNT = cssw_pkg::OLD_TICKS,
  parameter int NEW_CNT = cssw_pkg::NEW_TICKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // source ticks, one cycle each
  input wire logic lfrc_tick,
  input wire logic fastrc_tick,
  input wire logic primary_ext_tick,
  input wire logic timer1_tick,
  // source stability
  input wire logic fastrc_stable,
  input wire logic startup_timer_done,
  input wire logic timer1_stable,
  // configuration
  input wire logic cfg_loaded,
  input wire cssw_pkg::cssw_pmode_e cfg_primary_mode,
  // software control
  input wire logic sel_wr,
  input wire logic [1:0] sel_wdata,
  input wire logic freq_wr,
  input wire logic [2:0] freq_wdata,
  input wire logic idle_on_sleep_enable,
  input wire logic secondary_osc_enable,
  input wire logic sleep_exec,
  input wire logic wake_event,
  // status and clocks out
  output logic [1:0] system_clock_select,
  output logic [2:0] fast_rc_freq_select,
  output logic primary_startup_done_flag,
  output logic secondary_clock_active_flag,
  output cssw_pkg::cssw_src_e active_source,
  output logic switch_busy,
  output logic sys_clk_tick,
  output logic lfrc_feature_tick,
  output logic secondary_osc_run,
  output logic sleep_mode,
  output logic idle_mode
);
  import cssw_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (OLD_CNT < 1 || OLD_CNT > 7) begin : g_old_chk
    $error("OLD_CNT must lie in 1..7");
  end
  if (NEW_CNT < 1 || NEW_CNT > 7) begin : g_new_chk
    $error("NEW_CNT must lie in 1..7");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  cssw_state_e state_r, state_nxt; // switch sequencer
  cssw_src_e active_r; // source now clocking the device
  cssw_src_e pend_r; // source being switched to
  logic [1:0] sel_r; // software select field
  logic [2:0] freq_r; // fast rc postscaler select
  logic sleep_r, idle_r; // power-managed modes
  logic tick_r, lf_tick_r, sec_run_r; // registered clock strobes
  logic pflag_r, sflag_r; // status flags

  // ----------------------------------------
  // decode wires
  // ----------------------------------------
  logic [3:0] tick_vec; // ticks by source index
  logic [3:0] stable_vec; // stable levels by source index
  cssw_src_e primary_src; // what primary means under configuration
  cssw_src_e internal_src; // what internal means under the postscaler
  cssw_src_e sel_src; // raw decode of the select field
  cssw_src_e target_src; // decode after the timer1 guard
  logic want_switch; // target differs from the running source
  logic pwr_managed; // sleep or idle active

  cssw_cnt_if cnt_bus ();

  assign tick_vec = {timer1_tick, primary_ext_tick, fastrc_tick, lfrc_tick};
  // low-freq rc needs no settling; primary is ready once its startup timer expires
  assign stable_vec = {timer1_stable, startup_timer_done, fastrc_stable, 1'b1};

  // primary source follows the configuration mode
  assign primary_src = (cfg_primary_mode == internal_lf_mode) ? SRC_LFRC :
                       (cfg_primary_mode == internal_hf_mode ||
                        cfg_primary_mode == internal_pll_mode) ? SRC_FASTRC :
                       SRC_PRIMARY;
  // 31 khz setting runs straight from the low-freq rc
  assign internal_src = (freq_r == FREQ_LOW) ? SRC_LFRC : SRC_FASTRC;

  // 00 and 10 both land on primary; 11 can alias primary when it is internal
  assign sel_src = (sel_r == SEL_INTERNAL) ? internal_src :
                   (sel_r == SEL_SECOND) ? SRC_SECOND :
                   primary_src;
  // selecting timer1 with its oscillator off is simply not honoured
  assign target_src = (sel_src == SRC_SECOND && !secondary_osc_enable) ? active_r : sel_src;
  assign want_switch = (target_src != active_r);
  assign pwr_managed = sleep_r || idle_r;

  // ----------------------------------------
  // counter hookup
  // ----------------------------------------
  assign cnt_bus.tick_vec = tick_vec;
  assign cnt_bus.src = (state_r == ST_OLD) ? active_r : pend_r;
  assign cnt_bus.start = (state_nxt == ST_OLD && state_r != ST_OLD) ||
                         (state_nxt == ST_NEW && state_r != ST_NEW);
  assign cnt_bus.target = (state_r == ST_OLD) ? CNT_W'(OLD_CNT) : CNT_W'(NEW_CNT);

  cssw_tick_count u_count (
    .ref_clk (ref_clk),
    .rstn (rstn),
    .cnt (cnt_bus.counter)
  );

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  // the device clock is held off from the first old cycle to the last new one
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_BOOT: begin
        if (cfg_loaded) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (want_switch) begin
          state_nxt = ST_OLD;
        end
      end
      ST_OLD: begin
        if (cnt_bus.done) begin
          state_nxt = ST_STABLE;
        end
      end
      ST_STABLE: begin
        // a timer1 that is enabled but not yet stable can park the switch here a long time
        if (stable_vec[pend_r]) begin
          state_nxt = ST_NEW;
        end
      end
      ST_NEW: begin
        if (cnt_bus.done) begin
          state_nxt = ST_RUN;
        end
      end
      // codes outside the five states fall back to boot
      default: begin
        state_nxt = ST_BOOT;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= ST_BOOT;
      active_r <= SRC_LFRC;
      pend_r <= SRC_LFRC;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_BOOT && cfg_loaded) begin
        active_r <= primary_src;
      end else if (state_r == ST_NEW && cnt_bus.done) begin
        active_r <= pend_r;
      end
      if (state_r == ST_RUN && want_switch) begin
        pend_r <= target_src;
      end
    end
  end

  // ----------------------------------------
  // software fields
  // ----------------------------------------
  // reset always lands on primary at the 1 mhz postscaler step
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sel_r <= SEL_RESET;
      freq_r <= FREQ_RESET;
    end else begin
      if (sel_wr) begin
        sel_r <= sel_wdata;
      end
      if (freq_wr) begin
        freq_r <= freq_wdata;
      end
    end
  end

  // ----------------------------------------
  // power-managed modes
  // ----------------------------------------
  // wake wins over a sleep command in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sleep_r <= 1'b0;
      idle_r <= 1'b0;
    end else if (wake_event) begin
      sleep_r <= 1'b0;
      idle_r <= 1'b0;
    end else if (sleep_exec && !pwr_managed) begin
      idle_r <= idle_on_sleep_enable;
      sleep_r <= !idle_on_sleep_enable;
    end
  end

  // ----------------------------------------
  // clock strobes and status flags
  // ----------------------------------------
  // the system tick is gated during the pause and in full sleep
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick_r <= 1'b0;
      lf_tick_r <= 1'b0;
      sec_run_r <= 1'b0;
      pflag_r <= 1'b0;
      sflag_r <= 1'b0;
    end else begin
      tick_r <= (state_r == ST_RUN || state_r == ST_BOOT) && !sleep_r && tick_vec[active_r];
      lf_tick_r <= lfrc_tick;
      sec_run_r <= secondary_osc_enable;
      pflag_r <= state_r == ST_RUN && active_r == SRC_PRIMARY && startup_timer_done;
      sflag_r <= state_r == ST_RUN && active_r == SRC_SECOND;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign system_clock_select = sel_r;
  assign fast_rc_freq_select = freq_r;
  assign primary_startup_done_flag = pflag_r;
  assign secondary_clock_active_flag = sflag_r;
  assign active_source = active_r;
  assign switch_busy = (state_r != ST_RUN);
  assign sys_clk_tick = tick_r;
  assign lfrc_feature_tick = lf_tick_r;
  assign secondary_osc_run = sec_run_r;
  assign sleep_mode = sleep_r;
  assign idle_mode = idle_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // reset and boot
  reset_values_a: assert property ($rose(rstn) |-> sel_r == SEL_RESET && freq_r == FREQ_RESET)
    else $error("select or postscaler not at reset value");
  boot_lfrc_a: assert property (state_r == ST_BOOT |-> active_r == SRC_LFRC && !pflag_r && !sflag_r)
    else $error("boot not on low-freq rc");

  // switch sequence and pause
  no_direct_switch_a: assert property (state_r == ST_RUN && want_switch
    |=> active_r == $past(active_r) ##1 state_r != ST_RUN) else $error("source changed without transition");
  pause_gate_a: assert property (state_r == ST_OLD || state_r == ST_NEW || state_r == ST_STABLE
    |=> !tick_r) else $error("system tick during pause");
  old_cycles_a: assert property ($rose(state_r == ST_OLD) && !tick_vec[active_r]
    ##1 (!tick_vec[active_r])[*3] |-> state_r == ST_OLD) else $error("old-source pause cut short");
  stable_hold_a: assert property (state_r == ST_STABLE && !stable_vec[pend_r] |=> state_r == ST_STABLE)
    else $error("switch left before new source stable");
  default_alias_a: assert property (state_r == ST_RUN && !want_switch
    && (sel_r == SEL_DEFAULT || sel_r == SEL_PRIMARY) |-> active_r == primary_src)
    else $error("default select not on primary");
  sec_ignore_a: assert property (sel_r == SEL_SECOND && !secondary_osc_enable && state_r == ST_RUN
    && active_r != SRC_SECOND |=> pend_r != SRC_SECOND) else $error("timer1 select not ignored");

  // status flags
  flags_excl_a: assert property (!(pflag_r && sflag_r)) else $error("both status flags set");
  sec_flag_a: assert property (state_r == ST_RUN && active_r == SRC_SECOND |=> sflag_r)
    else $error("secondary active flag missing");
  prim_flag_a: assert property (pflag_r |-> $past(active_r) == SRC_PRIMARY && $past(startup_timer_done))
    else $error("primary flag without timed-out primary");

  // power-managed modes and feature clock
  sleep_choice_a: assert property (sleep_exec && !wake_event && !pwr_managed
    |=> idle_r == $past(idle_on_sleep_enable) && sleep_r == !$past(idle_on_sleep_enable))
    else $error("wrong power-managed mode");
  wake_clear_a: assert property (wake_event |=> !sleep_r && !idle_r)
    else $error("wake did not leave sleep or idle");
  sleep_gate_a: assert property (sleep_r |=> !tick_r)
    else $error("system tick while asleep");
  feature_tick_a: assert property (lfrc_tick |=> lf_tick_r)
    else $error("feature tick dropped");

  switch_done_c: cover property (state_r == ST_NEW && cnt_bus.done);
  idle_entry_c: cover property (sleep_exec && idle_on_sleep_enable && !pwr_managed);
  sleep_entry_c: cover property (sleep_exec && !idle_on_sleep_enable && !pwr_managed);
  boot_exit_c: cover property (state_r == ST_BOOT && cfg_loaded);

endmodule

`default_nettype wire

// file: tb/system_clock_source_switch_tb.sv
// self-checking bench for the system clock source switch
// assumes the switch top module and its package; the bench drives every port itself
`timescale 1ns/10ps
`default_nettype none

module system_clock_source_switch_tb;
  import cssw_pkg::*;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic ref_clk, rstn, lfrc_tick, fastrc_tick, primary_ext_tick, timer1_tick;
  logic fastrc_stable, startup_timer_done, timer1_stable, cfg_loaded;
  cssw_pmode_e cfg_primary_mode;
  logic sel_wr, freq_wr, idle_on_sleep_enable, secondary_osc_enable, sleep_exec, wake_event;
  logic [1:0] sel_wdata, system_clock_select;
  logic [2:0] freq_wdata, fast_rc_freq_select;
  logic primary_startup_done_flag, secondary_clock_active_flag, switch_busy, sys_clk_tick;
  logic lfrc_feature_tick, secondary_osc_run, sleep_mode, idle_mode;
  cssw_src_e active_source;
  wire logic [3:0] tick_vec = {timer1_tick, primary_ext_tick, fastrc_tick, lfrc_tick}; // by source index
  int err_total = 0, tests_run = 0;
  logic [31:0] rnd = 32'h65c9_a6a6; // fixed seed
  cssw_src_e exp_q[$]; // expected source after each switch
  bit watch_on = 0;
  logic busy_d = 1'b0, lf_d = 1'b0, rst_ok = 1'b0;
  // config modes and the source each one must lead to
  cssw_pmode_e mode_t[3] = '{internal_hf_mode, internal_lf_mode, external_clock_mode};
  cssw_src_e src_t[3] = '{SRC_FASTRC, SRC_LFRC, SRC_PRIMARY};

  cssw_clock_switch u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .lfrc_tick(lfrc_tick), .fastrc_tick(fastrc_tick),
    .primary_ext_tick(primary_ext_tick), .timer1_tick(timer1_tick), .fastrc_stable(fastrc_stable),
    .startup_timer_done(startup_timer_done), .timer1_stable(timer1_stable), .cfg_loaded(cfg_loaded),
    .cfg_primary_mode(cfg_primary_mode), .sel_wr(sel_wr), .sel_wdata(sel_wdata), .freq_wr(freq_wr),
    .freq_wdata(freq_wdata), .idle_on_sleep_enable(idle_on_sleep_enable),
    .secondary_osc_enable(secondary_osc_enable), .sleep_exec(sleep_exec), .wake_event(wake_event),
    .system_clock_select(system_clock_select), .fast_rc_freq_select(fast_rc_freq_select),
    .primary_startup_done_flag(primary_startup_done_flag),
    .secondary_clock_active_flag(secondary_clock_active_flag), .active_source(active_source),
    .switch_busy(switch_busy), .sys_clk_tick(sys_clk_tick), .lfrc_feature_tick(lfrc_feature_tick),
    .secondary_osc_run(secondary_osc_run), .sleep_mode(sleep_mode), .idle_mode(idle_mode)
  );

  // ----------------------------------------
  // clock, random source ticks
  // ----------------------------------------
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // ticks are random so pause lengths vary from switch to switch
  always @(posedge ref_clk) begin
    rnd = xs(rnd);
    lfrc_tick <= rnd[0];
    fastrc_tick <= rnd[5];
    primary_ext_tick <= rnd[9];
    timer1_tick <= rnd[14];
    lf_d <= lfrc_tick;
    rst_ok <= rstn;
  end

  // ----------------------------------------
  // compare, verdict
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watcher: end of a switch pops the oldest expected source
  always @(negedge ref_clk) begin
    busy_d <= switch_busy;
    if (watch_on && busy_d === 1'b1 && switch_busy === 1'b0) begin
      watch_on = 0;
      if (exp_q.size() == 0) chk(1, 0);
      else chk(active_source, exp_q.pop_front());
    end
    if (rstn === 1'b1 && rst_ok === 1'b1) begin
      chk(primary_startup_done_flag & secondary_clock_active_flag, 0);
      chk(lfrc_feature_tick, lf_d);
    end
  end

  // watchdog: far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wait_idle();
    int n, k;
    n = 0;
    k = 0;
    while (k < 4 && n < 500) begin
      @(negedge ref_clk);
      n++;
      k = (switch_busy === 1'b0) ? k + 1 : 0;
    end
    chk(n < 500, 1);
  endtask

  // one select write after which no switch may start
  task automatic sel_hold(input logic [1:0] v, input cssw_src_e src);
    @(posedge ref_clk);
    sel_wr <= 1'b1;
    sel_wdata <= v;
    @(posedge ref_clk);
    sel_wr <= 1'b0;
    repeat (20) begin
      @(negedge ref_clk);
      chk({switch_busy, active_source}, {1'b0, src});
    end
  endtask

  // write select and postscaler, then follow the whole pause
  task automatic do_switch(input logic [1:0] sel, input logic [2:0] frq, input cssw_src_e exp, input bit hold);
    int n, nt, st;
    cssw_src_e old;
    old = active_source;
    exp_q.push_back(exp);
    watch_on = 1;
    @(posedge ref_clk);
    sel_wr <= 1'b1;
    sel_wdata <= sel;
    freq_wr <= 1'b1;
    freq_wdata <= frq;
    @(posedge ref_clk);
    sel_wr <= 1'b0;
    freq_wr <= 1'b0;
    @(negedge ref_clk);
    chk(system_clock_select, sel);
    chk(fast_rc_freq_select, frq);
    chk(active_source, old);
    n = 0;
    while (switch_busy !== 1'b1 && n < 5) begin
      @(negedge ref_clk);
      n++;
    end
    chk(switch_busy, 1);
    if (hold) begin
      // new source unstable: switch must wait
      repeat (40) @(negedge ref_clk);
      chk(switch_busy, 1);
      chk(active_source, old);
      @(posedge ref_clk);
      startup_timer_done <= 1'b1;
    end
    n = 0;
    nt = 0;
    st = 0;
    while (switch_busy === 1'b1 && n < 300) begin
      if (n > 0) st += sys_clk_tick;
      nt += tick_vec[exp];
      n++;
      @(negedge ref_clk);
    end
    chk(st, 0);
    chk(n >= OLD_TICKS + NEW_TICKS && nt >= NEW_TICKS, 1);
    repeat (3) @(negedge ref_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    {sel_wr, freq_wr, sleep_exec, wake_event, cfg_loaded, secondary_osc_enable} = '0;
    {lfrc_tick, fastrc_tick, primary_ext_tick, timer1_tick, idle_on_sleep_enable} = '0;
    {fastrc_stable, timer1_stable, startup_timer_done} = 3'h7;
    sel_wdata = 2'h0;
    freq_wdata = 3'h0;
    cfg_primary_mode = crystal_mode;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(system_clock_select, SEL_RESET);
    chk(fast_rc_freq_select, FREQ_RESET);
    chk(active_source, SRC_LFRC);
    @(posedge ref_clk);
    rstn <= 1'b1;
    // boot: low-freq rc until configuration arrives
    repeat (20) @(negedge ref_clk);
    chk({switch_busy, active_source}, {1'b1, SRC_LFRC});
    @(posedge ref_clk);
    cfg_loaded <= 1'b1;
    wait_idle();
    chk(active_source, SRC_PRIMARY);
    chk({primary_startup_done_flag, secondary_clock_active_flag}, 2'h2);
    // internal block, then 31 khz postscaler setting
    do_switch(SEL_INTERNAL, FREQ_RESET, SRC_FASTRC, 0);
    chk({primary_startup_done_flag, secondary_clock_active_flag}, 2'h0);
    do_switch(SEL_INTERNAL, FREQ_LOW, SRC_LFRC, 0);
    // timer1 request refused while its oscillator is off
    sel_hold(SEL_SECOND, SRC_LFRC);
    @(posedge ref_clk);
    // timer1 stays stable from reset on, long before it is selected
    secondary_osc_enable <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(secondary_osc_run, 1);
    do_switch(SEL_SECOND, FREQ_LOW, SRC_SECOND, 0);
    chk({primary_startup_done_flag, secondary_clock_active_flag}, 2'h1);
    // primary not yet started: pause stretches until stable
    @(posedge ref_clk);
    startup_timer_done <= 1'b0;
    do_switch(SEL_PRIMARY, FREQ_RESET, SRC_PRIMARY, 1);
    chk({primary_startup_done_flag, secondary_clock_active_flag}, 2'h2);
    // default encoding follows configuration mode
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      cfg_primary_mode <= mode_t[i];
      do_switch(SEL_DEFAULT, FREQ_RESET, src_t[i], 0);
    end
    // 10 aliases 00 while primary is external: no switch
    sel_hold(SEL_PRIMARY, SRC_PRIMARY);
    do_switch(SEL_INTERNAL, FREQ_RESET, SRC_FASTRC, 0);
    // idle then sleep
    for (int i = 1; i >= 0; i--) begin
      int st;
      st = 0;
      @(posedge ref_clk);
      idle_on_sleep_enable <= i[0];
      sleep_exec <= 1'b1;
      @(posedge ref_clk);
      sleep_exec <= 1'b0;
      @(negedge ref_clk);
      chk({idle_mode, sleep_mode}, {i[0], ~i[0]});
      @(negedge ref_clk);
      repeat (12) begin
        @(negedge ref_clk);
        st += sys_clk_tick;
      end
      chk(st != 0, i);
      chk(secondary_osc_run, 1);
      @(posedge ref_clk);
      wake_event <= 1'b1;
      @(posedge ref_clk);
      wake_event <= 1'b0;
      @(negedge ref_clk);
      chk({idle_mode, sleep_mode}, 2'h0);
    end
    // reset in mid-run returns to the configured primary
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk({system_clock_select, fast_rc_freq_select}, {SEL_RESET, FREQ_RESET});
    wait_idle();
    chk(active_source, SRC_PRIMARY);
    wrap_up();
  end
endmodule

`default_nettype wire
